// File: rbp_pkg.sv
// Shared constants and carrier types of the parity memory board controller.
package rbp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 50;   // Clock period.
  localparam int ACC_NS      = 200;  // Longest access time to the array.
  localparam int REF_NS      = 400;  // Longest refresh cycle.
  localparam int REF_INT_NS  = 14000; // Default refresh interval.
  localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC     = (REF_NS / CLK_NS < 1) ? 1 : REF_NS / CLK_NS;
  localparam int REF_INT_CYC = REF_INT_NS / CLK_NS;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;  // Configuration.
  localparam logic [7:0] OFF_STAT = 8'h04;  // Sticky events, write one to clear.
  localparam logic [7:0] OFF_MASK = 8'h08;  // Interrupt mask, same layout.
  localparam logic [7:0] OFF_ERR0 = 8'h0C;  // First error register.
  localparam logic [7:0] OFF_ERR1 = 8'h10;  // Second error register.

  // Control fields.
  localparam int CF_MODE    = 0;   // Two bits: 0 = 16, 1 = 20, 2 = 24 address bits.
  localparam int CF_EXTREF  = 2;   // External refresh timing.
  localparam int CF_EXTPAR  = 3;   // External parity source.
  localparam int CF_ADV     = 4;   // Two bits: cycles of acknowledge advance.
  localparam int CF_DUAL    = 6;   // Use both error registers.
  localparam int CF_INTEN0  = 7;   // Interrupt enable of error register 0.
  localparam int CF_LVL0    = 8;   // Three bits: level of error register 0.
  localparam int CF_INTEN1  = 11;  // Interrupt enable of error register 1.
  localparam int CF_LVL1    = 12;  // Three bits: level of error register 1.
  localparam int CF_IOPORT  = 16;  // Eight bits: I/O port of the error registers.
  localparam logic [31:0] CTRL_RST = 32'h0000_0042;  // 24-bit mode, dual.

  localparam logic [1:0] MODE_16 = 2'h0;
  localparam logic [1:0] MODE_20 = 2'h1;

  // Status and mask bits.
  localparam int SB_CAP0 = 0;  // Error register 0 captured a location.
  localparam int SB_CAP1 = 1;  // Error register 1 captured a location.
  localparam int SB_OVR  = 2;  // Error seen while no register in use was free.
  localparam int SB_W    = 3;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        req;    // Memory command present.
    logic        wr;     // Write when high, read when low.
    logic        hi_en;  // Odd byte takes part.
    logic        lo_en;  // Even byte takes part.
    logic [23:0] addr;   // Byte address from the master.
    logic [15:0] wdata;  // Write data.
  } rbp_sysreq_t;

  typedef struct packed {
    logic        valid;  // A location is held.
    logic        hi;     // Odd byte failed.
    logic        lo;     // Even byte failed.
    logic [4:0]  bank;   // Bank of the failing word.
    logic [7:0]  row;    // Row of the failing word.
  } rbp_err_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACC  = 4'b0010,
    ST_REL  = 4'b0100,
    ST_REF  = 4'b1000
  } rbp_state_t;

endpackage

// File: rbp_decode.sv
// Start address decoder driven by three hexadecimal switches.
`timescale 1ns/1ns
module rbp_decode #(
  parameter int SIZE_LOG2 = 11
) (
  input  wire logic [11:0]          sw_base,
  input  wire logic [1:0]           mode,
  input  wire logic [23:0]          addr,
  output logic                      hit,
  output logic [SIZE_LOG2-2:0]      word_idx
);

  // Elaboration stops on a window that the 24-bit compare cannot hold.
  if (SIZE_LOG2 < 2 || SIZE_LOG2 > 24) begin : g_bad_size
    $error("rbp_decode: SIZE_LOG2 out of range");
  end

  // ---------------------------------------------------------------
  // Address width masking
  // ---------------------------------------------------------------
  // Short masters leave the upper lines floating, so they are forced to zero.
  function automatic logic [23:0] eff_addr(input logic [23:0] a, input logic [1:0] m);
    if (m == rbp_pkg::MODE_16) begin
      eff_addr = {8'h00, a[15:0]};
    end else if (m == rbp_pkg::MODE_20) begin
      eff_addr = {4'h0, a[19:0]};
    end else begin
      eff_addr = a;
    end
  endfunction

  logic [24:0] ea;    // Effective address, one bit wider for the compare.
  logic [24:0] base;  // Switch value times 4096.
  logic [24:0] offs;  // Byte offset into the board.

  // Base is the switch value with twelve zero bits appended; no boundary rule.
  always_comb begin
    ea       = {1'b0, eff_addr(addr, mode)};
    base     = {1'b0, sw_base, 12'h000};
    offs     = ea - base;
    hit      = (ea >= base) && (offs < (25'h1 << SIZE_LOG2));
    word_idx = offs[SIZE_LOG2-1:1];
  end

endmodule

// File: rbp_refresh.sv
// Refresh request source: internal interval divider or external control.
`timescale 1ns/1ns
module rbp_refresh #(
  parameter int INTERVAL_CYC = rbp_pkg::REF_INT_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic use_ext,
  input  wire logic ext_req,
  input  wire logic grant,
  output logic      pending
);

  // The divider is 16 bits wide, and an interval must outlast one refresh.
  if (INTERVAL_CYC < rbp_pkg::REF_CYC + 2 || INTERVAL_CYC > 65536) begin : g_bad_interval
    $error("rbp_refresh: refresh interval out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt;   // Interval divider.
    logic        ext_d; // Previous external level, for edge detection.
    logic        pend;  // Refresh owed to the array.
  } rbp_ref_st_t;

  rbp_ref_st_t st_ff;
  rbp_ref_st_t nxt_st;
  logic        tick;    // One-cycle refresh demand.

  // Divider runs always; the selected source alone raises a demand.
  always_comb begin
    nxt_st = st_ff;
    tick   = 1'b0;
    if (st_ff.cnt == 16'(INTERVAL_CYC - 1)) begin
      nxt_st.cnt = 16'h0000;
      tick       = !use_ext;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    nxt_st.ext_d = ext_req;
    if (use_ext && ext_req && !st_ff.ext_d) begin
      tick = 1'b1;
    end
    // A demand in the grant cycle survives: set wins over clear.
    if (tick) begin
      nxt_st.pend = 1'b1;
    end else if (grant) begin
      nxt_st.pend = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pending = st_ff.pend;

  property p_ext_edge;
    @(posedge clk) disable iff (!reset_n)
      (use_ext && ext_req && !st_ff.ext_d) |=> pending;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external refresh lost");

endmodule

// File: rbp_board.sv
// Top of the parity memory board controller with switch decode and error registers.
//
// Overview of operation
// - Base address from three hex switches, 4K resolution.
// - Start address is switch value times 4096.
// - Start anywhere in 16 MB; 16/20/24-bit addresses.
// - Store parity on write, check it on read.
// - Parity catches any single bit error.
// - Mismatch latches row and bank, interrupts, LED.
// - Each error register routes its own interrupt.
// - One or both error registers usable.
// - Error registers on configurable I/O port, level.
// - Internal refresh, or external refresh control.
// - Parity from internal generator or external source.
// - Optional advanced acknowledge, selectable advance.
// - Byte and word transfers both served.
`timescale 1ns/1ns
module rbp_board #(
  parameter int SIZE_LOG2    = 11,
  parameter int REF_INT_CYC  = rbp_pkg::REF_INT_CYC
) (
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic [11:0]         SW_BASE,
  input  wire rbp_pkg::rbp_sysreq_t SYS,
  output logic                     XACK,
  output logic [15:0]              RDATA,
  input  wire logic [1:0]          EXT_PARITY,
  input  wire logic                EXT_REFRESH,
  input  wire logic                IO_RD,
  input  wire logic [7:0]          IO_ADDR,
  output logic                     IO_ACK,
  output logic [15:0]              IO_RDATA,
  output logic [7:0]               INT_LINES,
  output logic                     ERR_LED,
  output logic                     IRQ
);

  localparam int AW = SIZE_LOG2 - 1;   // Word index width.
  localparam int NW = 1 << AW;         // Words in the array.
  localparam logic [3:0] ACC_LAST = 4'(rbp_pkg::ACC_CYC - 1);
  localparam logic [3:0] REF_LAST = 4'(rbp_pkg::REF_CYC - 1);

  // Row and bank fields, the 4-bit cycle counter and a 3-cycle advance bound the sizes.
  if (AW < 9 || AW > 13 || rbp_pkg::ACC_CYC < 4 || rbp_pkg::ACC_CYC > 16 ||
      rbp_pkg::REF_CYC > 16) begin : g_bad_cfg
    $error("rbp_board: SIZE_LOG2 must give room for row and bank fields");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rbp_pkg::rbp_state_t  fsm;    // Sequencer state.
    logic [3:0]           cnt;    // Cycle within an access or refresh.
    rbp_pkg::rbp_sysreq_t req;    // Command taken at the start of an access.
    logic [AW-1:0]        idx;    // Word index of that command.
    logic [15:0]          rdata;  // Read data to the master.
    rbp_pkg::rbp_err_t    err0;   // First error register.
    rbp_pkg::rbp_err_t    err1;   // Second error register.
    logic [rbp_pkg::SB_W-1:0] stat;  // Sticky events.
    logic [rbp_pkg::SB_W-1:0] mask;  // Interrupt mask.
    logic [31:0]          ctrl;   // Configuration.
    logic [31:0]          prdata; // APB read data.
    logic [15:0]          io_rdata; // I/O port read data.
    logic                 io_ack; // I/O port answer.
  } rbp_st_t;

  rbp_st_t st_ff;
  rbp_st_t nxt_st;

  // Array: two byte lanes with one stored parity bit each.
  logic [7:0] mem_lo [NW];
  logic [7:0] mem_hi [NW];
  logic       par_lo [NW];
  logic       par_hi [NW];

  logic          hit;        // Command falls on this board.
  logic [AW-1:0] word_idx;   // Word index of the current command.
  logic          ref_pend;   // Refresh owed.
  logic          ref_grant;  // Refresh starts this cycle.
  logic          accept;     // Memory command taken this cycle.
  logic          commit;     // Last access cycle: array written or read.
  logic          perr;       // Parity mismatch at commit.
  logic          rel0;       // Error register 0 is being read out.
  logic          rel1;       // Error register 1 is being read out.
  logic [1:0]    wpar;       // Parity stored by a write.
  logic [15:0]   mdata;      // Word at the current index.
  logic [1:0]    adv;        // Acknowledge advance in cycles.
  logic          apb_wr;     // APB write access phase.
  logic          apb_setup;  // APB setup phase.
  logic [7:0]    row;        // Row of the current word.
  logic [4:0]    bank;       // Bank of the current word.

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rbp_decode #(.SIZE_LOG2(SIZE_LOG2)) u_decode (
    .sw_base  (SW_BASE),
    .mode     (st_ff.ctrl[rbp_pkg::CF_MODE +: 2]),
    .addr     (SYS.addr),
    .hit      (hit),
    .word_idx (word_idx)
  );

  rbp_refresh #(.INTERVAL_CYC(REF_INT_CYC)) u_refresh (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .use_ext  (st_ff.ctrl[rbp_pkg::CF_EXTREF]),
    .ext_req  (EXT_REFRESH),
    .grant    (ref_grant),
    .pending  (ref_pend)
  );

  // Packs an error register into its software view.
  function automatic logic [15:0] err_view(input rbp_pkg::rbp_err_t e);
    err_view = e;
  endfunction

  // ---------------------------------------------------------------
  // Datapath decode
  // ---------------------------------------------------------------
  // Parity is one bit per byte lane, so any single flipped bit shows.
  always_comb begin
    mdata     = {mem_hi[st_ff.idx], mem_lo[st_ff.idx]};
    adv       = st_ff.ctrl[rbp_pkg::CF_ADV +: 2];
    accept    = (st_ff.fsm == rbp_pkg::ST_IDLE) && !ref_pend && SYS.req && hit;
    ref_grant = (st_ff.fsm == rbp_pkg::ST_IDLE) && ref_pend;
    commit    = (st_ff.fsm == rbp_pkg::ST_ACC) && (st_ff.cnt == ACC_LAST);
    row       = st_ff.idx[7:0];
    bank      = 5'(st_ff.idx >> 8);
    if (st_ff.ctrl[rbp_pkg::CF_EXTPAR]) begin
      wpar = EXT_PARITY;
    end else begin
      wpar = {^st_ff.req.wdata[15:8], ^st_ff.req.wdata[7:0]};
    end
    perr = commit && !st_ff.req.wr &&
           ((st_ff.req.lo_en && ((^mdata[7:0]) != par_lo[st_ff.idx])) ||
            (st_ff.req.hi_en && ((^mdata[15:8]) != par_hi[st_ff.idx])));
    apb_setup = PSEL && !PENABLE;
    apb_wr    = PSEL && PENABLE && PWRITE;
    rel0 = (IO_RD && (IO_ADDR == st_ff.ctrl[rbp_pkg::CF_IOPORT +: 8])) ||
           (PSEL && PENABLE && !PWRITE && (PADDR == rbp_pkg::OFF_ERR0));
    rel1 = (IO_RD && (IO_ADDR == st_ff.ctrl[rbp_pkg::CF_IOPORT +: 8] + 8'h01)) ||
           (PSEL && PENABLE && !PWRITE && (PADDR == rbp_pkg::OFF_ERR1));
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.io_ack = 1'b0;
    // Sequencer: refresh has priority so the array never misses one.
    case (st_ff.fsm)
      rbp_pkg::ST_IDLE: begin
        nxt_st.cnt = 4'h0;
        if (ref_grant) begin
          nxt_st.fsm = rbp_pkg::ST_REF;
        end else if (accept) begin
          nxt_st.fsm = rbp_pkg::ST_ACC;
          nxt_st.req = SYS;
          nxt_st.idx = word_idx;
        end
      end
      rbp_pkg::ST_ACC: begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
        if (commit) begin
          if (!st_ff.req.wr) begin
            nxt_st.rdata = mdata;
          end
          nxt_st.fsm = rbp_pkg::ST_REL;
        end
      end
      rbp_pkg::ST_REL: begin
        // The master holds its command until it sees the acknowledge.
        if (!SYS.req) begin
          nxt_st.fsm = rbp_pkg::ST_IDLE;
        end
      end
      rbp_pkg::ST_REF: begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
        if (st_ff.cnt == REF_LAST) begin
          nxt_st.fsm = rbp_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st.fsm = rbp_pkg::ST_IDLE;
      end
    endcase

    // Register writes; status bits clear on a written one.
    if (apb_wr) begin
      case (PADDR)
        rbp_pkg::OFF_CTRL: nxt_st.ctrl = PWDATA;
        rbp_pkg::OFF_STAT: nxt_st.stat = st_ff.stat & ~PWDATA[rbp_pkg::SB_W-1:0];
        rbp_pkg::OFF_MASK: nxt_st.mask = PWDATA[rbp_pkg::SB_W-1:0];
        default: begin
        end
      endcase
    end

    // Readout frees an error register for the next capture.
    if (rel0) begin
      nxt_st.err0.valid = 1'b0;
    end
    if (rel1) begin
      nxt_st.err1.valid = 1'b0;
    end

    // Capture goes to the first free register in use (err1 only when dual); set wins over clear.
    if (perr) begin
      if (!st_ff.err0.valid) begin
        nxt_st.err0 = {1'b1, (^mdata[15:8]) != par_hi[st_ff.idx] && st_ff.req.hi_en,
                       (^mdata[7:0]) != par_lo[st_ff.idx] && st_ff.req.lo_en,
                       bank, row};
        nxt_st.stat[rbp_pkg::SB_CAP0] = 1'b1;
      end else if (st_ff.ctrl[rbp_pkg::CF_DUAL] && !st_ff.err1.valid) begin
        nxt_st.err1 = {1'b1, (^mdata[15:8]) != par_hi[st_ff.idx] && st_ff.req.hi_en,
                       (^mdata[7:0]) != par_lo[st_ff.idx] && st_ff.req.lo_en,
                       bank, row};
        nxt_st.stat[rbp_pkg::SB_CAP1] = 1'b1;
      end else begin
        nxt_st.stat[rbp_pkg::SB_OVR] = 1'b1;
      end
    end

    // I/O port read of the error registers, answered in the next cycle.
    if (IO_RD) begin
      nxt_st.io_ack = 1'b1;
      if (IO_ADDR == st_ff.ctrl[rbp_pkg::CF_IOPORT +: 8]) begin
        nxt_st.io_rdata = err_view(st_ff.err0);
      end else if (IO_ADDR == st_ff.ctrl[rbp_pkg::CF_IOPORT +: 8] + 8'h01) begin
        nxt_st.io_rdata = err_view(st_ff.err1);
      end else begin
        nxt_st.io_ack   = 1'b0;
      end
    end

    // APB read data is caught in the setup phase, so a zero-wait answer holds.
    if (apb_setup) begin
      case (PADDR)
        rbp_pkg::OFF_CTRL: nxt_st.prdata = st_ff.ctrl;
        rbp_pkg::OFF_STAT: nxt_st.prdata = {29'h0, st_ff.stat};
        rbp_pkg::OFF_MASK: nxt_st.prdata = {29'h0, st_ff.mask};
        rbp_pkg::OFF_ERR0: nxt_st.prdata = {16'h0000, err_view(st_ff.err0)};
        rbp_pkg::OFF_ERR1: nxt_st.prdata = {16'h0000, err_view(st_ff.err1)};
        default:           nxt_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff      <= '0;
      st_ff.fsm  <= rbp_pkg::ST_IDLE;
      st_ff.ctrl <= rbp_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Array write with per-lane enables; memory content has no reset.
  always_ff @(posedge CLK) begin
    if (commit && st_ff.req.wr) begin
      if (st_ff.req.lo_en) begin
        mem_lo[st_ff.idx] <= st_ff.req.wdata[7:0];
        par_lo[st_ff.idx] <= wpar[0];
      end
      if (st_ff.req.hi_en) begin
        mem_hi[st_ff.idx] <= st_ff.req.wdata[15:8];
        par_hi[st_ff.idx] <= wpar[1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Advance pulls the acknowledge earlier; data still lands at the last cycle.
  assign XACK      = (st_ff.fsm == rbp_pkg::ST_ACC) && (st_ff.cnt == ACC_LAST - 4'(adv));
  assign RDATA     = st_ff.rdata;
  assign PRDATA    = st_ff.prdata;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && (PADDR > rbp_pkg::OFF_ERR1 || PADDR[1:0] != 2'h0);
  assign IO_ACK    = st_ff.io_ack;
  assign IO_RDATA  = st_ff.io_rdata;
  assign ERR_LED   = st_ff.err0.valid || st_ff.err1.valid;
  assign IRQ       = |(st_ff.stat & st_ff.mask);
  assign INT_LINES = ((st_ff.err0.valid && st_ff.ctrl[rbp_pkg::CF_INTEN0]) ?
                      (8'h01 << st_ff.ctrl[rbp_pkg::CF_LVL0 +: 3]) : 8'h00) |
                     ((st_ff.err1.valid && st_ff.ctrl[rbp_pkg::CF_INTEN1]) ?
                      (8'h01 << st_ff.ctrl[rbp_pkg::CF_LVL1 +: 3]) : 8'h00);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_start;
    accept;
  endsequence
  sequence s_ack_win;
    ##[1:4] XACK;
  endsequence

  property p_ack_bound;
    @(posedge CLK) disable iff (!RESET_N) s_start |-> s_ack_win;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("acknowledge late");
  property p_adv_pos;
    @(posedge CLK) disable iff (!RESET_N) XACK |-> ##[0:3] commit;
  endproperty
  a_adv_pos: assert property (p_adv_pos) else $error("advance wrong");
  property p_base;
    @(posedge CLK) disable iff (!RESET_N)
      (accept && st_ff.ctrl[rbp_pkg::CF_MODE +: 2] > rbp_pkg::MODE_20)
      |-> SYS.addr[23:12] >= SW_BASE;
  endproperty
  a_base: assert property (p_base) else $error("accepted below base");
  property p_wpar;
    @(posedge CLK) disable iff (!RESET_N)
      (commit && st_ff.req.wr && st_ff.req.lo_en && !st_ff.ctrl[rbp_pkg::CF_EXTPAR])
      |=> par_lo[$past(st_ff.idx)] == ^mem_lo[$past(st_ff.idx)];
  endproperty
  a_wpar: assert property (p_wpar) else $error("stored parity wrong");
  property p_cap0;
    @(posedge CLK) disable iff (!RESET_N)
      (perr && !st_ff.err0.valid) |=> st_ff.err0.valid && st_ff.err0.row == $past(row)
                                      ##1 ERR_LED;
  endproperty
  a_cap0: assert property (p_cap0) else $error("capture missed");
  property p_hold;
    @(posedge CLK) disable iff (!RESET_N)
      (st_ff.err0.valid && !rel0) |=> st_ff.err0 == $past(st_ff.err0);
  endproperty
  a_hold: assert property (p_hold) else $error("held error overwritten");
  property p_single;
    @(posedge CLK) disable iff (!RESET_N)
      (perr && st_ff.err0.valid && !st_ff.ctrl[rbp_pkg::CF_DUAL])
      |=> st_ff.stat[rbp_pkg::SB_OVR] && $stable(st_ff.err1);
  endproperty
  a_single: assert property (p_single) else $error("second register used");
  property p_route;
    @(posedge CLK) disable iff (!RESET_N)
      !st_ff.ctrl[rbp_pkg::CF_INTEN0] && !st_ff.ctrl[rbp_pkg::CF_INTEN1] |-> INT_LINES == 8'h00;
  endproperty
  a_route: assert property (p_route) else $error("disabled line driven");
  property p_irq;
    @(posedge CLK) disable iff (!RESET_N)
      $rose(st_ff.stat[rbp_pkg::SB_CAP0]) && st_ff.mask[rbp_pkg::SB_CAP0] |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

// File: rbp_master.sv
// Bus master model that issues memory cycles to the board.
`timescale 1ns/1ns
module rbp_master (
  input  wire logic            CLK,
  input  wire logic            XACK,
  input  wire logic [15:0]     RDATA,
  output rbp_pkg::rbp_sysreq_t SYS
);
  int waited;  // Edges that the last command waited for its acknowledge.
  initial SYS = '0;
  // Request held until acknowledge; released lines show inverted data.
  task automatic mem(input logic w, input logic [1:0] en, input logic [23:0] a,
                     input logic [15:0] d, output logic ok, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge CLK);
    SYS <= '{req:1'b1, wr:w, hi_en:en[1], lo_en:en[0], addr:a, wdata:d};
    do begin @(posedge CLK); n++; end while (XACK !== 1'b1 && n < 40);
    ok = XACK;
    waited = n;
    SYS <= '{req:1'b0, wr:~w, hi_en:~en[1], lo_en:~en[0], addr:~a, wdata:~d};
    repeat (4) @(posedge CLK);
    r = RDATA;
  endtask
endmodule

// File: rbp_board_tb.sv
// Self-checking bench of the parity memory board controller.
`timescale 1ns/1ns
module rbp_board_tb;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, slv, xack, ack;
  logic io_rd, ioack, led, irq, ext;
  logic [7:0] paddr, io_addr, intl;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rdata, iodat, md;
  logic [1:0] xpar;
  int fail_count = 0, total_checks = 0, cyc = 0;
  rbp_pkg::rbp_sysreq_t sys;
  localparam logic [23:0] BASE = 24'h180000;
  rbp_board #(.SIZE_LOG2(11), .REF_INT_CYC(20)) i_rbp_board (
    .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SW_BASE(12'h180), .SYS(sys), .XACK(xack), .RDATA(rdata),
    .EXT_PARITY(xpar), .EXT_REFRESH(ext), .IO_RD(io_rd), .IO_ADDR(io_addr),
    .IO_ACK(ioack), .IO_RDATA(iodat), .INT_LINES(intl), .ERR_LED(led), .IRQ(irq));
  rbp_master i_rbp_master (.CLK(clk), .XACK(xack), .RDATA(rdata), .SYS(sys));
  initial begin clk = 0; forever #25 clk = ~clk; end
  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin fail_count++; test_done(); end
  end
  task test_done();
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One APB transfer; read data and error flag taken at the ready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && cyc < 20000);
    r = prdata; slv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Last word of the board, byte lane merge, and both edges of the window.
  task t_mem();
    i_rbp_master.mem(1, 2'b11, BASE + 24'h7FE, 16'hA55A, ack, md); chk(ack, 1);
    i_rbp_master.mem(1, 2'b10, BASE + 24'h7FE, 16'h3CFF, ack, md);
    i_rbp_master.mem(0, 2'b11, BASE + 24'h7FE, 16'h0, ack, md); chk(md, 16'h3C5A);
    chk(led, 0);
    i_rbp_master.mem(1, 2'b11, BASE - 24'h2, 16'h1, ack, md); chk(ack, 0);
    i_rbp_master.mem(1, 2'b11, BASE + 24'h800, 16'h1, ack, md); chk(ack, 0);
  endtask
  // Stored parity forced both ways; exactly one word must fail on read.
  task t_parity();
    apb(0, 8'h00, 0); chk(r, 32'h42);
    apb(1, 8'h08, 32'h1);
    apb(1, 8'h00, 32'h004003CA);
    i_rbp_master.mem(1, 2'b11, BASE, 16'h0101, ack, md);
    xpar <= 2'b11;
    i_rbp_master.mem(1, 2'b11, BASE + 24'h2, 16'h0101, ack, md);
    apb(1, 8'h00, 32'h004003C2);
    i_rbp_master.mem(0, 2'b11, BASE, 16'h0, ack, md);
    i_rbp_master.mem(0, 2'b11, BASE + 24'h2, 16'h0, ack, md);
    chk(led, 1);
    chk(irq, 1);
    chk(intl, 8'h08);
    i_rbp_master.mem(0, 2'b11, BASE, 16'h0, ack, md);
    apb(0, 8'h10, 0); chk(r[15:13], 3'h7);
    apb(1, 8'h00, 32'h00400382);
    i_rbp_master.mem(0, 2'b11, BASE, 16'h0, ack, md);
    apb(0, 8'h04, 0); chk(r, 32'h7);
    io_rd <= 1'b1; io_addr <= 8'h40;
    @(posedge clk) io_rd <= 1'b0;
    @(posedge clk) chk(ioack, 1);
    chk(iodat[15:1], 15'h7000);
    chk(led, 0);
    apb(1, 8'h04, 32'h7); @(posedge clk); chk(irq, 0);
    apb(0, 8'h20, 0); chk(slv, 1); chk(r, 0);
  endtask
  // Three cycles of advance, an external refresh demand, then 20-bit masking.
  task t_adv();
    apb(1, 8'h00, 32'h004003F6);
    repeat (10) @(posedge clk);
    i_rbp_master.mem(0, 2'b11, BASE + 24'h2, 16'h0, ack, md); chk(ack, 1);
    chk(i_rbp_master.waited, rbp_pkg::ACC_CYC - 2);
    chk(md, 16'h0101);
    ext <= 1'b1;
    @(posedge clk) ext <= 1'b0;
    i_rbp_master.mem(0, 2'b11, BASE + 24'h2, 16'h0, ack, md);
    chk(i_rbp_master.waited, rbp_pkg::ACC_CYC - 2 + rbp_pkg::REF_CYC);
    apb(1, 8'h00, 32'h004003F5);
    i_rbp_master.mem(0, 2'b11, BASE + 24'h2, 16'h0, ack, md); chk(ack, 0);
  endtask
  initial begin
    reset_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    io_rd = 0; io_addr = 0; xpar = 0; ext = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_mem();
    t_parity();
    t_adv();
    test_done();
  end
endmodule
